// file: bench/urxs_endpoint_rx_bench.sv
`include "urxs_consts.svh"

module urxs_endpoint_rx_bench;
	timeunit 1ns;
	timeprecision 1ns;
	localparam logic [31:0] ad_rxs = `URXS_RXS_IDX << 2;
	localparam logic [31:0] ad_rxc = `URXS_RXC_IDX << 2;
	localparam logic [31:0] ad_wev = `URXS_WEV_IDX << 2;
	localparam logic [31:0] ad_icl = `URXS_ICL_IDX << 2;
	localparam logic [31:0] ad_ien = `URXS_IEN_IDX << 2;
	logic pclk = 1'h0;
	logic presetn = 1'h0;
	logic psel = 1'h0;
	logic penable = 1'h0;
	logic pwrite = 1'h0;
	logic [31:0] paddr = 32'h0;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rdat;
	logic pready, pslverr, irq, rerr, frame_number_lsb, ep_iso, rx_busy, byte_in, byte_out;
	logic s_err = 1'h0, s_setup = 1'h0, s_tog = 1'h0, s_last = 1'h0;
	urxs_pkg::urxs_mac_evt_t mac_evt;
	urxs_pkg::urxs_ctrl_t ep_ctrl;
	int occ = 0, n_fail = 0, tests_run = 0, seed = 50661;
	int lim[4] = '{0, 5, 9, 17};
	// Byte lanes always enabled
	urxs_endpoint_rx DUT (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.pstrb(4'hF), .prdata, .pready, .pslverr, .mac_evt, .frame_number_lsb, .ep_iso,
		.rx_busy, .byte_in, .byte_out, .ep_ctrl, .irq);
	urxs_mac_model mac (.pclk, .ep_ctrl, .mac_evt, .frame_number_lsb, .ep_iso, .rx_busy,
		.byte_in, .byte_out);
	always #20 pclk = ~pclk;
	task automatic stop_test();
		$display("%0d checks, %0d mismatches", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : stop_test
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			n_fail++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask : chk
	// Idle edge first so back-to-back calls never drive psel twice at once
	task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		@(posedge pclk);
		while (pready !== 1'h1)
			@(posedge pclk);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : bus
	task automatic rc(input logic [31:0] a, input logic [31:0] e);
		bus(1'h0, a, 32'h0);
		chk(rdat, e);
	endtask : rc
	// Status read returns old flags, then setup, toggle and last clear
	task automatic rs();
		rc(ad_rxs, {24'h0, s_err, s_setup, s_tog, s_last, occ > 15 ? 4'hF : 4'(occ)});
		s_setup = 1'h0;
		s_tog = 1'h0;
		s_last = 1'h0;
	endtask : rs
	task automatic rx(input logic s, input logic d1, input int n);
		mac.pkt(s, d1, n);
		occ += n;
		s_setup |= s;
		s_tog = ep_iso ? frame_number_lsb : d1;
		s_last |= !ep_iso;
	endtask : rx
	// Hang guard, far beyond the run length
	initial
	begin
		#400000;
		n_fail++;
		stop_test();
	end
	initial
	begin
		repeat (20) @(posedge pclk);
		presetn <= 1'h1;
		rs();
		rc(ad_rxc, 32'h0);
		// Random packets push the count past fifteen
		repeat (4)
		begin
			bus(1'h1, ad_rxc, 32'h1);
			rx(1'h0, 1'($random(seed)), 4 + $unsigned($random(seed)) % 5);
			rc(ad_rxc, 32'h0);
			rs();
		end
		rx(1'h1, 1'h0, 8);
		rs();
		bus(1'h1, ad_rxc, 32'h4);
		mac.pulse(6'h38);
		chk(32'(ep_ctrl.setup_token_disregard), 32'h1);
		rs();
		mac.lvl(1'h1, 1'($random(seed)), 1'h0);
		bus(1'h1, ad_rxc, 32'h1);
		rx(1'h0, 1'h1, 3);
		rs();
		chk(32'(ep_ctrl.nak_on_full), 32'h0);
		mac.lvl(1'h0, 1'h0, 1'h0);
		bus(1'h1, ad_rxc, 32'h1);
		mac.pulse(6'h01);
		rc(ad_rxc, 32'h0);
		mac.drain(2);
		occ -= 2;
		// Fill to eight free bytes and try every limit code
		while (occ < 56)
		begin
			bus(1'h1, ad_rxc, 32'h1);
			rx(1'h0, 1'h0, occ > 48 ? 56 - occ : 8);
		end
		for (int c = 0; c < 4; c++)
		begin
			bus(1'h1, ad_rxc, c << 5);
			rc(ad_wev, 32'(c > 0 && 64 - occ < lim[c]));
		end
		mac.pulse(6'h04);
		s_err = 1'h1;
		rs();
		// Purge held off while a reception is in progress
		mac.lvl(1'h0, 1'h0, 1'h1);
		bus(1'h1, ad_rxc, 32'h8);
		rc(ad_rxc, 32'h8);
		rs();
		mac.lvl(1'h0, 1'h0, 1'h0);
		repeat (3) @(posedge pclk);
		occ = 0;
		s_err = 1'h0;
		rs();
		// Old events cleared first so only the new setup can raise the line
		bus(1'h1, ad_icl, 32'hF);
		bus(1'h1, ad_ien, 32'h1);
		@(posedge pclk);
		chk(32'(irq), 32'h0);
		rx(1'h1, 1'h0, 1);
		rs();
		chk(32'(irq), 32'h1);
		bus(1'h1, ad_icl, 32'hF);
		@(posedge pclk);
		chk(32'(irq), 32'h0);
		// Idle purge empties the FIFO straight away
		bus(1'h1, ad_rxc, 32'h8);
		occ = 0;
		rs();
		bus(1'h0, 32'h0, 32'h0);
		chk(32'(rerr), 32'h1);
		stop_test();
	end
endmodule : urxs_endpoint_rx_bench

// file: bench/urxs_endpoint_rx_props.sv
`include "urxs_consts.svh"

module urxs_endpoint_rx_props (
	// APB side
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	input wire logic pready,
	// Engine side
	input wire logic rx_busy,
	input wire logic ep_iso,
	input wire urxs_pkg::urxs_mac_evt_t mac_evt,
	input wire urxs_pkg::urxs_ctrl_t ep_ctrl
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// Control write landing at this edge; a firmware enable may win over a drop
	wire logic ctl_wr = psel && penable && pwrite && pstrb[0] && paddr == (`URXS_RXC_IDX << 2);
	// Zero wait states, answer only in the access cycle
	a_ready_now: assert property (psel && penable |-> pready)
		else $error("no pready in access");
	a_ready_once: assert property (pready |-> penable && !$past(penable))
		else $error("pready out of place");
	// Purge takes the cycle after the write, never during reception
	a_purge_now: assert property (ctl_wr && pwdata[3] && !rx_busy |=> ep_ctrl.flush)
		else $error("purge not applied");
	a_flush_once: assert property (ep_ctrl.flush |=> !ep_ctrl.flush)
		else $error("flush too long");
	a_flush_idle: assert property (ep_ctrl.flush |-> !$past(rx_busy))
		else $error("flush during reception");
	// Receive enable drops after data or an OUT stall
	a_en_data: assert property (mac_evt.good && !mac_evt.setup && !ctl_wr |=> !ep_ctrl.rx_enable)
		else $error("enable kept after data");
	a_en_stall: assert property (mac_evt.stall_out && !ctl_wr |=> !ep_ctrl.rx_enable)
		else $error("enable kept after stall");
	a_iso_nak: assert property (presetn |=> ep_ctrl.nak_on_full == !$past(ep_iso))
		else $error("nak on iso endpoint");
	c_flush: cover property (ep_ctrl.flush);
	c_stall: cover property (mac_evt.stall_out);
	c_iso: cover property (ep_iso && mac_evt.good);
endmodule : urxs_endpoint_rx_props

bind urxs_endpoint_rx urxs_endpoint_rx_props u_props (.pclk, .presetn, .psel, .penable, .pwrite,
	.paddr, .pwdata, .pstrb, .pready, .rx_busy, .ep_iso, .mac_evt, .ep_ctrl);

// file: bench/urxs_mac_model.sv
module urxs_mac_model (
	// Clock and endpoint controls
	input wire logic pclk,
	input wire urxs_pkg::urxs_ctrl_t ep_ctrl,
	// Engine outputs
	output urxs_pkg::urxs_mac_evt_t mac_evt,
	output logic frame_number_lsb,
	output logic ep_iso,
	output logic rx_busy,
	output logic byte_in,
	output logic byte_out
);
	timeunit 1ns;
	timeprecision 1ns;
	// Quiet engine from time zero
	initial
	begin
		mac_evt = '0;
		frame_number_lsb = 1'h0;
		ep_iso = 1'h0;
		rx_busy = 1'h0;
		byte_in = 1'h0;
		byte_out = 1'h0;
	end
	// One-cycle event; caller sits just after an edge
	task automatic pulse(input urxs_pkg::urxs_mac_evt_t e);
		mac_evt <= e;
		@(posedge pclk);
		mac_evt <= '0;
	endtask : pulse
	task automatic lvl(input logic iso, input logic fl, input logic b);
		ep_iso <= iso;
		frame_number_lsb <= fl;
		rx_busy <= b;
	endtask : lvl
	// Edge first so a just-written enable is seen; iso gets no handshake
	task automatic pkt(input logic s, input logic d1, input int n);
		@(posedge pclk);
		if (!s && ep_ctrl.rx_enable !== 1'h1)
			return;
		rx_busy <= 1'h1;
		byte_in <= 1'h1;
		repeat (n) @(posedge pclk);
		byte_in <= 1'h0;
		pulse({1'h1, s, d1, 1'h0, !ep_iso, 1'h0});
		rx_busy <= 1'h0;
	endtask : pkt
	task automatic drain(input int n);
		byte_out <= 1'h1;
		repeat (n) @(posedge pclk);
		byte_out <= 1'h0;
	endtask : drain
endmodule : urxs_mac_model

// file: design/urxs_endpoint_rx.sv
`include "urxs_consts.svh"

module urxs_endpoint_rx (
	// APB slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Receive engine side
	input urxs_pkg::urxs_mac_evt_t mac_evt,
	input wire logic frame_number_lsb,
	input wire logic ep_iso,
	input wire logic rx_busy,
	input wire logic byte_in,
	input wire logic byte_out,
	output urxs_pkg::urxs_ctrl_t ep_ctrl,
	// Interrupt
	output logic irq
);

	// Bus phase decode
	logic setup_ph;
	logic done_ph;
	logic wr_done;
	logic rd_done;
	logic [29:0] widx;
	logic hit_rxs;
	logic hit_rxc;
	logic hit_wev;
	logic hit_ist;
	logic hit_icl;
	logic hit_ien;
	logic mapped;

	// Register state
	logic [31:0] prdata_q;
	logic [31:0] prdata_d;
	logic pready_q;
	logic pready_d;
	logic pslverr_q;
	logic pslverr_d;
	logic err_q;
	logic err_d;
	logic setup_q;
	logic setup_d;
	logic toggle_q;
	logic toggle_d;
	logic last_q;
	logic last_d;
	logic [2:0] rdmask_q;
	logic [2:0] rdmask_d;
	logic [1:0] wl_q;
	logic [1:0] wl_d;
	logic ign_q;
	logic ign_d;
	logic rxen_q;
	logic rxen_d;
	logic wev_q;
	logic wev_d;
	logic [`URXS_EV_W-1:0] ist_q;
	logic [`URXS_EV_W-1:0] ist_d;
	logic [`URXS_EV_W-1:0] ien_q;
	logic [`URXS_EV_W-1:0] ien_d;
	logic [`URXS_EV_W-1:0] ev;
	logic irq_q;
	logic irq_d;
	logic nak_q;
	logic nak_d;
	urxs_pkg::urxs_flush_st_t fl_q;
	urxs_pkg::urxs_flush_st_t fl_d;
	logic flush_q;
	logic flush_d;

	// FIFO occupancy
	logic [6:0] level;
	logic [6:0] free_bytes;
	logic [3:0] count4;
	logic warn_now;
	logic setup_ok;
	logic data_pkt;

	urxs_fifo_occ u_occ (
		.pclk(pclk),
		.presetn(presetn),
		.byte_in(byte_in),
		.byte_out(byte_out),
		.flush(flush_q),
		.level_q(level)
	);

	// Address decode against the word index
	assign widx = paddr[31:2];
	assign hit_rxs = (widx == 30'(`URXS_RXS_IDX));
	assign hit_rxc = (widx == 30'(`URXS_RXC_IDX));
	assign hit_wev = (widx == 30'(`URXS_WEV_IDX));
	assign hit_ist = (widx == 30'(`URXS_IST_IDX));
	assign hit_icl = (widx == 30'(`URXS_ICL_IDX));
	assign hit_ien = (widx == 30'(`URXS_IEN_IDX));
	assign mapped = hit_rxs | hit_rxc | hit_wev | hit_ist | hit_icl | hit_ien;
	assign setup_ph = psel && !penable;
	assign done_ph = psel && penable && pready_q;
	assign wr_done = done_ph && pwrite && !pslverr_q && pstrb[0];
	assign rd_done = done_ph && !pwrite;

	// Saturating byte count and free space
	assign count4 = (level > `URXS_CNT_MAX) ? 4'hF : level[3:0];
	assign free_bytes = `URXS_FIFO_DEPTH - level;

	// Warning threshold decode
	always_comb
	begin
		unique case (wl_q)
			`URXS_WL_5: warn_now = (free_bytes < `URXS_LIM_5);
			`URXS_WL_9: warn_now = (free_bytes < `URXS_LIM_9);
			`URXS_WL_17: warn_now = (free_bytes < `URXS_LIM_17);
			default: warn_now = 1'b0;
		endcase
	end

	// Ignored SETUP packets never reach the flags
	assign setup_ok = mac_evt.good && mac_evt.setup && !ign_q;
	assign data_pkt = mac_evt.good && !mac_evt.setup;

	// Read data and bus answer, captured in the setup cycle
	always_comb
	begin
		prdata_d = `URXS_RESET_VAL;
		rdmask_d = 3'h0;
		pready_d = 1'b0;
		pslverr_d = 1'b0;
		if (setup_ph)
		begin
			pready_d = 1'b1;
			pslverr_d = !mapped;
			if (!pwrite && hit_rxs)
			begin
				prdata_d[`URXS_RXS_ERR] = err_q;
				prdata_d[`URXS_RXS_SETUP] = setup_q;
				prdata_d[`URXS_RXS_TOGGLE] = toggle_q;
				prdata_d[`URXS_RXS_LAST] = last_q;
				prdata_d[`URXS_RXS_CNT_HI:`URXS_RXS_CNT_LO] = count4;
				rdmask_d = {setup_q, toggle_q, last_q};
			end
			else if (!pwrite && hit_rxc)
			begin
				prdata_d[`URXS_RXC_WL_HI:`URXS_RXC_WL_LO] = wl_q;
				prdata_d[`URXS_RXC_FLUSH] = (fl_q == urxs_pkg::URXS_FL_WAIT);
				prdata_d[`URXS_RXC_IGN] = ign_q;
				prdata_d[`URXS_RXC_EN] = rxen_q;
			end
			else if (!pwrite && hit_wev)
				prdata_d[`URXS_WEV_RX_SPACE_WARNING] = wev_q;
			else if (!pwrite && hit_ist)
				prdata_d[`URXS_EV_W-1:0] = ist_q;
			else if (!pwrite && hit_ien)
				prdata_d[`URXS_EV_W-1:0] = ien_q;
		end
		else if (psel && penable && !pready_q)
		begin
			pready_d = 1'b1;
			pslverr_d = pslverr_q;
			prdata_d = prdata_q;
			rdmask_d = rdmask_q;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata_q <= `URXS_RESET_VAL;
			rdmask_q <= 3'h0;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end
		else
		begin
			prdata_q <= prdata_d;
			rdmask_q <= rdmask_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
		end
	end

	// Receive status flags: only bits that were returned are cleared,
	// so an event landing between capture and completion survives
	always_comb
	begin
		setup_d = setup_q;
		toggle_d = toggle_q;
		last_d = last_q;
		err_d = err_q;
		if (rd_done && hit_rxs)
		begin
			setup_d = setup_q & ~rdmask_q[2];
			toggle_d = toggle_q & ~rdmask_q[1];
			last_d = last_q & ~rdmask_q[0];
		end
		if (setup_ok)
			setup_d = 1'b1;
		if (mac_evt.good && (setup_ok || !mac_evt.setup))
			toggle_d = ep_iso ? frame_number_lsb : mac_evt.data1;
		if (mac_evt.ack)
			last_d = 1'b1;
		if (flush_q)
			err_d = 1'b0;
		if (mac_evt.err)
			err_d = 1'b1;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			setup_q <= 1'b0;
			toggle_q <= 1'b0;
			last_q <= 1'b0;
			err_q <= 1'b0;
		end
		else
		begin
			setup_q <= setup_d;
			toggle_q <= toggle_d;
			last_q <= last_d;
			err_q <= err_d;
		end
	end

	// Control register; a firmware re-enable beats a same-cycle drop
	always_comb
	begin
		wl_d = wl_q;
		ign_d = ign_q;
		rxen_d = rxen_q;
		ien_d = ien_q;
		if (data_pkt || mac_evt.stall_out)
			rxen_d = 1'b0;
		if (wr_done && hit_rxc)
		begin
			wl_d = pwdata[`URXS_RXC_WL_HI:`URXS_RXC_WL_LO];
			ign_d = pwdata[`URXS_RXC_IGN];
			if (pwdata[`URXS_RXC_EN])
				rxen_d = 1'b1;
		end
		if (wr_done && hit_ien)
			ien_d = pwdata[`URXS_EV_W-1:0];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			wl_q <= `URXS_WL_OFF;
			ign_q <= 1'b0;
			rxen_q <= 1'b0;
			ien_q <= '0;
		end
		else
		begin
			wl_q <= wl_d;
			ign_q <= ign_d;
			rxen_q <= rxen_d;
			ien_q <= ien_d;
		end
	end

	// Purge sequencing: held off while a packet is landing in the FIFO
	always_comb
	begin
		fl_d = fl_q;
		flush_d = 1'b0;
		unique case (fl_q)
			urxs_pkg::URXS_FL_IDLE:
			begin
				if (wr_done && hit_rxc && pwdata[`URXS_RXC_FLUSH])
				begin
					if (rx_busy)
						fl_d = urxs_pkg::URXS_FL_WAIT;
					else
						flush_d = 1'b1;
				end
			end
			urxs_pkg::URXS_FL_WAIT:
			begin
				if (!rx_busy)
				begin
					fl_d = urxs_pkg::URXS_FL_IDLE;
					flush_d = 1'b1;
				end
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			fl_q <= urxs_pkg::URXS_FL_IDLE;
			flush_q <= 1'b0;
		end
		else
		begin
			fl_q <= fl_d;
			flush_q <= flush_d;
		end
	end

	// Event register, interrupt status and line; set beats clear
	assign ev[`URXS_EV_SETUP] = setup_ok;
	assign ev[`URXS_EV_ACK] = mac_evt.ack;
	assign ev[`URXS_EV_ERR] = mac_evt.err;
	assign ev[`URXS_EV_WARN] = warn_now && !wev_q;

	always_comb
	begin
		wev_d = wev_q;
		ist_d = ist_q;
		if (rd_done && hit_wev)
			wev_d = 1'b0;
		if (warn_now)
			wev_d = 1'b1;
		if (wr_done && hit_icl)
			ist_d = ist_q & ~pwdata[`URXS_EV_W-1:0];
		ist_d = ist_d | ev;
		irq_d = |(ist_d & ien_d);
		nak_d = !ep_iso;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			wev_q <= 1'b0;
			ist_q <= '0;
			irq_q <= 1'b0;
			nak_q <= 1'b0;
		end
		else
		begin
			wev_q <= wev_d;
			ist_q <= ist_d;
			irq_q <= irq_d;
			nak_q <= nak_d;
		end
	end

	// Outputs straight from flops
	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;
	assign irq = irq_q;
	assign ep_ctrl.rx_enable = rxen_q;
	assign ep_ctrl.setup_token_disregard = ign_q;
	assign ep_ctrl.flush = flush_q;
	assign ep_ctrl.nak_on_full = nak_q;

endmodule : urxs_endpoint_rx

// file: design/urxs_fifo_occ.sv
`include "urxs_consts.svh"

module urxs_fifo_occ (
	// Clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// FIFO activity
	input wire logic byte_in,
	input wire logic byte_out,
	input wire logic flush,
	// Occupancy
	output logic [6:0] level_q
);

	logic [6:0] level_d;

	// Flush clears the level count, so occupancy drops to zero
	always_comb
	begin
		level_d = level_q;
		if (flush)
			level_d = 7'h00;
		else if (byte_in && !byte_out && level_q != `URXS_FIFO_DEPTH)
			level_d = level_q + 7'h01;
		else if (byte_out && !byte_in && level_q != 7'h00)
			level_d = level_q - 7'h01;
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			level_q <= 7'h00;
		else
			level_q <= level_d;
	end

endmodule : urxs_fifo_occ

// file: pkg/urxs_consts.svh
`ifndef URXS_CONSTS_SVH
`define URXS_CONSTS_SVH

// Register indices; byte address is four times the index
`define URXS_RXS_IDX 32'h5000187C
`define URXS_RXC_IDX 32'h5000187E
`define URXS_WEV_IDX 32'h50001880
`define URXS_IST_IDX 32'h50001881
`define URXS_ICL_IDX 32'h50001882
`define URXS_IEN_IDX 32'h50001883

// Receive status fields
`define URXS_RXS_ERR 7
`define URXS_RXS_SETUP 6
`define URXS_RXS_TOGGLE 5
`define URXS_RXS_LAST 4
`define URXS_RXS_CNT_HI 3
`define URXS_RXS_CNT_LO 0

// Receive control fields
`define URXS_RXC_WL_HI 6
`define URXS_RXC_WL_LO 5
`define URXS_RXC_FLUSH 3
`define URXS_RXC_IGN 2
`define URXS_RXC_EN 0

// Warning limit codes and free-byte thresholds
`define URXS_WL_OFF 2'h0
`define URXS_WL_5 2'h1
`define URXS_WL_9 2'h2
`define URXS_WL_17 2'h3
`define URXS_LIM_5 7'h05
`define URXS_LIM_9 7'h09
`define URXS_LIM_17 7'h11

// FIFO geometry and count saturation
`define URXS_FIFO_DEPTH 7'h40
`define URXS_CNT_MAX 7'h0F

// Event and interrupt bits
`define URXS_EV_W 4
`define URXS_EV_SETUP 0
`define URXS_EV_ACK 1
`define URXS_EV_ERR 2
`define URXS_EV_WARN 3
`define URXS_WEV_RX_SPACE_WARNING 0

`define URXS_RESET_VAL 32'h0000_0000

`endif

// file: pkg/urxs_pkg.sv
package urxs_pkg;

	// Per-cycle pulses from the receive engine
	typedef struct packed {
		logic good;
		logic setup;
		logic data1;
		logic err;
		logic ack;
		logic stall_out;
	} urxs_mac_evt_t;

	// Controls handed back to the receive engine
	typedef struct packed {
		logic rx_enable;
		logic setup_token_disregard;
		logic flush;
		logic nak_on_full;
	} urxs_ctrl_t;

	typedef enum logic [0:0] {
		URXS_FL_IDLE,
		URXS_FL_WAIT
	} urxs_flush_st_t;

endpackage : urxs_pkg
